// ===== sdc_map.vh
`ifndef SDC_MAP_VH
`define SDC_MAP_VH

// Frame geometry
`define SDC_BYTE_BITS 8
`define SDC_FRAME_BITS 11'h010
`define SDC_BITS_PER_DEV_SHIFT 4
`define SDC_CNT_W 11
`define SDC_CNT_MAX 11'h7FF

// Field positions inside a received byte
`define SDC_FRAME_TYPE_BIT 7
`define SDC_RW_BIT 6
`define SDC_CLEAR_BIT 5

// Two-bit byte prefixes
`define SDC_STATUS_PREFIX 2'h3
`define SDC_HEADER_PREFIX 2'h2

// Chain limits
`define SDC_MAX_POS 6'h3F

// Reset values
`define SDC_REG_RESET 8'h00
`define SDC_SYNC_IDLE 3'h2

// Least chip-select high time, kept by the controller
`define SDC_CS_GAP_NS 500
`define SDC_CLK_NS 10
`define SDC_CS_GAP_CYC ((`SDC_CS_GAP_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)

`endif

// ===== sdc_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pin inputs
module sdc_sync #(
   parameter WIDTH = 3,
   parameter [WIDTH-1:0] IDLE = {WIDTH{1'b0}}
)
(
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Asynchronous inputs and synchronised copies
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] meta_q; // First stage, read only by the second

   // Both stages load the idle level under reset
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         meta_q <= IDLE;
         dout <= IDLE;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end

endmodule

`default_nettype wire

// ===== sdc_spi_target.v
`include "sdc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module sdc_spi_target #(
   parameter AW = 6,
   parameter DW = 8
)
(
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Serial link pins
   input wire sclk,
   input wire chip_select_n,
   input wire sdi,
   output reg sdo,
   output reg sdo_oe,
   // Fault events from the driver core
   input wire supply_undervoltage_flag,
   input wire pump_undervoltage_flag,
   input wire overcurrent_flag,
   input wire stall_flag,
   input wire thermal_flag,
   input wire open_load_flag,
   // Register write notification
   output reg wr_stb,
   output reg [AW-1:0] wr_addr,
   output reg [DW-1:0] wr_data,
   // Status towards the core
   output reg [5:0] fault_flags,
   output reg spi_error,
   output reg frame_err,
   output reg global_clear,
   output reg [5:0] chain_position,
   output reg [5:0] device_count
);
   // Frame decode states
   localparam [2:0] M_FIRST = 3'h0; // First byte not yet seen
   localparam [2:0] M_STD = 3'h1; // Standard 16-bit frame
   localparam [2:0] M_CNT = 3'h2; // Counting upstream status bytes
   localparam [2:0] M_SECOND_HEADER_BYTE = 3'h3; // Waiting for second header
   localparam [2:0] M_CHAIN = 3'h4; // Chain payload
   localparam [2:0] M_BAD = 3'h5; // Malformed frame
   wire [2:0] pins_s; // Synchronised sclk, select, data
   wire sclk_s, cs_n_s, sdi_s; // Synchronised pins by name
   reg sclk_d_q; // Previous sampled clock level
   reg cs_d_q; // Previous sampled select level
   reg [`SDC_CNT_W-1:0] fcnt_q; // Falling edges seen in frame
   reg [`SDC_CNT_W-1:0] rcnt_q; // Rising edges seen in frame
   reg ovf_q; // Falling count saturated
   reg [6:0] in_sh_q; // Partial input byte
   reg [7:0] prev_byte_q; // Last complete input byte
   reg prev_own_q; // Last byte was our address byte
   reg [7:0] tx_q; // Output shifter
   reg [2:0] mode_q; // Frame decode state
   reg [5:0] pos_q; // Upstream status bytes counted
   reg [5:0] cnt_q; // Devices in chain
   reg [7:0] own_a_q; // Byte index of our address byte
   reg [7:0] own_d_q; // Byte index of our data byte
   reg [`SDC_CNT_W-1:0] exp_q; // Expected falling edges
   reg rw_q; // Access flag of our command
   reg [AW-1:0] addr_q; // Our register address
   reg [DW-1:0] data_q; // Our write value
   reg [DW-1:0] rep_q; // Report byte
   reg clr_req_q; // Global clear requested
   reg [DW-1:0] mem [0:(1<<AW)-1]; // Register contents
   integer i; // Register array reset index
   wire sclk_fall, sclk_rise, cs_rise; // Clock edges while selected, select rise at frame end
   wire byte_done, payload, is_own_a, is_own_d; // Byte decode terms
   wire frame_ok, do_clear; // Frame end terms
   wire [7:0] in_byte, byte_idx, out_idx; // Byte value and indices
   wire [7:0] status_byte, next_tx, launch; // Output byte sources
   wire [5:0] fault_ev; // Fault events in status order

   // Pins cross into the core clock
   sdc_sync #(.WIDTH(3), .IDLE(`SDC_SYNC_IDLE)) u_sync (.core_clk(core_clk), .rst_n(rst_n),
      .din({sdi, chip_select_n, sclk}), .dout(pins_s));
   assign sclk_s = pins_s[0];
   assign cs_n_s = pins_s[1];
   assign sdi_s = pins_s[2];
   // Edges count only while selected
   assign sclk_fall = ~cs_n_s & sclk_d_q & ~sclk_s;
   assign sclk_rise = ~cs_n_s & ~sclk_d_q & sclk_s;
   assign cs_rise = cs_n_s & ~cs_d_q;
   // Byte assembly, first bit in is the top bit
   assign in_byte = {in_sh_q, sdi_s};
   assign byte_idx = fcnt_q[10:3];
   assign out_idx = rcnt_q[10:3];
   assign byte_done = sclk_fall & (fcnt_q[2:0] == 3'h7) & ~ovf_q;
   assign payload = (mode_q == M_STD) | (mode_q == M_CHAIN);
   // Our command byte: first byte of a standard frame or own chain slot
   assign is_own_a = ((mode_q == M_FIRST) & ~in_byte[`SDC_FRAME_TYPE_BIT]) |
      (payload & (byte_idx == own_a_q));
   assign is_own_d = payload & (byte_idx == own_d_q);
   // Frame accepted only with the exact clock count
   assign frame_ok = payload & ~ovf_q & (fcnt_q == exp_q);
   assign do_clear = cs_rise & frame_ok & (mode_q == M_CHAIN) & clr_req_q;
   // Fault events in status order
   assign fault_ev = {supply_undervoltage_flag, pump_undervoltage_flag, overcurrent_flag,
      stall_flag, thermal_flag, open_load_flag};
   assign status_byte = {`SDC_STATUS_PREFIX, fault_flags};
   // Next output byte: own status first, then input one byte late with the report in our address byte's place
   assign next_tx = (out_idx == 8'h00) ? status_byte :
      (prev_own_q ? rep_q : prev_byte_q);
   // Byte boundary loads a fresh byte, otherwise the shifter goes on
   assign launch = (rcnt_q[2:0] == 3'h0) ? next_tx : tx_q;

   // Link sampling, output shifting and frame decode
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         sclk_d_q <= 1'b0;
         cs_d_q <= 1'b1;
         fcnt_q <= {`SDC_CNT_W{1'b0}};
         rcnt_q <= {`SDC_CNT_W{1'b0}};
         ovf_q <= 1'b0;
         in_sh_q <= 7'h00;
         prev_byte_q <= 8'h00;
         prev_own_q <= 1'b0;
         tx_q <= 8'h00;
         mode_q <= M_FIRST;
         pos_q <= 6'h00;
         cnt_q <= 6'h00;
         own_a_q <= 8'h00;
         own_d_q <= 8'h01;
         exp_q <= `SDC_FRAME_BITS;
         rw_q <= 1'b1;
         addr_q <= {AW{1'b0}};
         data_q <= {DW{1'b0}};
         rep_q <= {DW{1'b0}};
         clr_req_q <= 1'b0;
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
         wr_stb <= 1'b0;
         wr_addr <= {AW{1'b0}};
         wr_data <= {DW{1'b0}};
         fault_flags <= 6'h00;
         spi_error <= 1'b0;
         frame_err <= 1'b0;
         global_clear <= 1'b0;
         chain_position <= 6'h00;
         device_count <= 6'h00;
         for (i = 0; i < (1 << AW); i = i + 1)
            mem[i] <= `SDC_REG_RESET;
      end
      else
      begin
         sclk_d_q <= sclk_s;
         cs_d_q <= cs_n_s;
         sdo_oe <= ~cs_n_s;
         wr_stb <= 1'b0;
         frame_err <= 1'b0;
         global_clear <= do_clear;
         // Sticky faults; a new event wins over a clear
         fault_flags <= (do_clear ? 6'h00 : fault_flags) | fault_ev;
         // Frame end: commit write or flag error
         if (cs_rise)
         begin
            if (frame_ok)
            begin
               // A chain clear also drops the sticky error flag spi_error
               if (do_clear)
                  spi_error <= 1'b0;
               if (!rw_q)
               begin
                  mem[addr_q] <= data_q;
                  wr_stb <= 1'b1;
                  wr_addr <= addr_q;
                  wr_data <= data_q;
               end
            end
            else
            begin
               frame_err <= 1'b1;
               spi_error <= 1'b1;
            end
         end
         // Deselected: reset frame state, pins ignored
         if (cs_n_s)
         begin
            fcnt_q <= {`SDC_CNT_W{1'b0}};
            rcnt_q <= {`SDC_CNT_W{1'b0}};
            ovf_q <= 1'b0;
            prev_own_q <= 1'b0;
            mode_q <= M_FIRST;
            pos_q <= 6'h00;
            own_a_q <= 8'h00;
            own_d_q <= 8'h01;
            exp_q <= `SDC_FRAME_BITS;
            rw_q <= 1'b1;
            clr_req_q <= 1'b0;
         end
         else
         begin
            // Launch one bit per rising edge
            if (sclk_rise)
            begin
               sdo <= launch[7];
               tx_q <= {launch[6:0], 1'b0};
               if (rcnt_q != `SDC_CNT_MAX)
                  rcnt_q <= rcnt_q + 11'h001;
            end
            // Sample one bit per falling edge
            if (sclk_fall)
            begin
               in_sh_q <= in_byte[6:0];
               if (fcnt_q == `SDC_CNT_MAX)
                  ovf_q <= 1'b1;
               else
                  fcnt_q <= fcnt_q + 11'h001;
            end
            // Whole byte received
            if (byte_done)
            begin
               prev_byte_q <= in_byte;
               prev_own_q <= is_own_a;
               if (is_own_a)
               begin
                  rw_q <= in_byte[`SDC_RW_BIT];
                  addr_q <= in_byte[AW-1:0];
                  rep_q <= mem[in_byte[AW-1:0]];
               end
               if (is_own_d)
                  data_q <= in_byte;
               case (mode_q)
                  M_FIRST, M_CNT:
                  begin
                     if (!in_byte[`SDC_FRAME_TYPE_BIT])
                        mode_q <= (mode_q == M_FIRST) ? M_STD : M_BAD;
                     else if (in_byte[7:6] == `SDC_STATUS_PREFIX)
                     begin
                        if (pos_q == `SDC_MAX_POS)
                           mode_q <= M_BAD;
                        else
                        begin
                           pos_q <= pos_q + 6'h01;
                           mode_q <= M_CNT;
                        end
                     end
                     else
                     begin
                        // First header: count, own byte slots, expected length
                        cnt_q <= in_byte[5:0];
                        own_a_q <= {1'b0, pos_q, 1'b0} + 8'h02;
                        own_d_q <= {1'b0, pos_q, 1'b0} + {2'h0, in_byte[5:0]} + 8'h02;
                        exp_q <= `SDC_FRAME_BITS + {1'b0, in_byte[5:0], 4'h0};
                        mode_q <= (in_byte[5:0] <= pos_q) ? M_BAD : M_SECOND_HEADER_BYTE;
                     end
                  end
                  M_SECOND_HEADER_BYTE:
                  begin
                     if (in_byte[7:6] == `SDC_HEADER_PREFIX)
                     begin
                        clr_req_q <= in_byte[`SDC_CLEAR_BIT];
                        chain_position <= pos_q;
                        device_count <= cnt_q;
                        mode_q <= M_CHAIN;
                     end
                     else
                        mode_q <= M_BAD;
                  end
                  default:
                     mode_q <= mode_q;
               endcase
            end
         end
      end
   end
endmodule

`default_nettype wire

// ===== sdc_spi_target_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the pins and strobes of the serial target
module sdc_spi_chk
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Link pins
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic sdo,
   input wire logic sdo_oe,
   // Fault events
   input wire logic supply_undervoltage_flag,
   input wire logic pump_undervoltage_flag,
   input wire logic overcurrent_flag,
   input wire logic stall_flag,
   input wire logic thermal_flag,
   input wire logic open_load_flag,
   // Strobes and flags
   input wire logic wr_stb,
   input wire logic [5:0] fault_flags,
   input wire logic spi_error,
   input wire logic frame_err,
   input wire logic global_clear
);
   // Fault events in flag order
   wire [5:0] fin = {supply_undervoltage_flag, pump_undervoltage_flag, overcurrent_flag,
      stall_flag, thermal_flag, open_load_flag};
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   chk_oe_release: assert property (chip_select_n [*6] |-> !sdo_oe)
      else $error("sdo driven while deselected");
   chk_oe_drive: assert property ((!chip_select_n) [*6] |-> sdo_oe)
      else $error("sdo released while selected");
   chk_sdo_launch: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> $past(sclk, 3))
      else $error("sdo changed without a clock rise");
   chk_wr_deselect: assert property (wr_stb |-> chip_select_n)
      else $error("write committed inside a frame");
   chk_err_no_wr: assert property (frame_err |-> !wr_stb)
      else $error("write with frame error");
   chk_err_sticky: assert property (frame_err |=> spi_error)
      else $error("frame error not kept");
   chk_wr_single: assert property (wr_stb |=> !wr_stb)
      else $error("write strobe longer than a cycle");
   chk_fault_latch: assert property ((fin & ~fault_flags) != 6'h00
      |=> (fault_flags & $past(fin)) == $past(fin))
      else $error("fault event not latched");
   chk_clear_all: assert property (global_clear |-> ##[0:2] (fault_flags == 6'h00 && !spi_error))
      else $error("global clear left faults");
endmodule
`default_nettype wire

// ===== sdc_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// Controller on the far side of the link
module sdc_spi_host
(
   // Pins towards the target
   output var logic sclk,
   output var logic chip_select_n,
   output var logic sdi,
   // Returned line, Z when released
   input wire logic sdo_line
);
   // Idle: deselected, clock low
   initial
   begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      sdi = 1'b0;
   end
   // One frame of n bits, first bit from din[n-1]
   task automatic xfer(input int n, input logic [63:0] din, output logic [63:0] dout);
      dout = 64'h0;
      chip_select_n = 1'b0; // Clock is low here
      #201; // Offset keeps every pin edge off the core clock edges
      for (int i = n - 1; i >= 0; i--)
      begin
         sclk = 1'b1;
         sdi = din[i]; // Most significant first
         #62.5;
         sclk = 1'b0;
         dout = {dout[62:0], sdo_line};
         #62.5;
      end
      #100;
      chip_select_n = 1'b1; // Clock low again
      // Noise while deselected, ends with clock low
      repeat (4)
      begin
         #50;
         sclk = ~sclk;
         sdi = ~sdi;
      end
      #400; // Gap of 600 ns
   endtask
endmodule
`default_nettype wire

// ===== sdc_spi_target_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench of the serial target
module sdc_spi_target_bench;
   // Clock, reset and fault events
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] fin = 6'h00;
   // Link and status nets
   wire sclk, chip_select_n, sdi, sdo, sdo_oe, wr_stb, spi_error, frame_err, global_clear;
   wire [5:0] wr_addr, fault_flags, chain_position, device_count;
   wire [7:0] wr_data;
   // Released output reads as Z
   wire sdo_line = sdo_oe ? sdo : 1'bz;
   // Counters and reply word
   int fails = 0;
   int check_count = 0;
   int wr_n = 0;
   int err_n = 0;
   int clr_n = 0;
   logic [63:0] r;
   always #5 core_clk = ~core_clk;
   // Counts strobes of the design
   always @(posedge core_clk)
   begin
      wr_n <= wr_n + (wr_stb === 1'b1);
      err_n <= err_n + (frame_err === 1'b1);
      clr_n <= clr_n + (global_clear === 1'b1);
   end
   sdc_spi_target uut (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk),
      .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
      .supply_undervoltage_flag(fin[5]), .pump_undervoltage_flag(fin[4]),
      .overcurrent_flag(fin[3]), .stall_flag(fin[2]), .thermal_flag(fin[1]),
      .open_load_flag(fin[0]), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
      .fault_flags(fault_flags), .spi_error(spi_error), .frame_err(frame_err),
      .global_clear(global_clear), .chain_position(chain_position),
      .device_count(device_count));
   sdc_spi_host host (.sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi),
      .sdo_line(sdo_line));
   // Compares one value
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One frame with reply and write count
   task automatic frame(input int n, input logic [63:0] din, input logic [63:0] exp, input int w);
      int w0;
      w0 = wr_n;
      @(negedge core_clk);
      host.xfer(n, din, r);
      check("reply", r, exp);
      check("writes", 64'(wr_n - w0), 64'(w));
      $display("test frame of %0d bits done", n);
   endtask
   // Counts, verdict, end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Cuts a hang short
   initial
   begin
      #200000;
      fails++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      repeat (20) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (5) @(negedge core_clk);
      frame(16, 64'h15A5, 64'hC000, 1);
      check("write", {wr_addr, wr_data}, 64'h15A5);
      frame(16, 64'h5500, 64'hC0A5, 0);
      frame(16, 64'h153C, 64'hC0A5, 1);
      frame(15, 64'h0AFF, 64'h601E, 0);
      @(negedge core_clk);
      host.xfer(17, 64'h02BFF, r);
      check("errors", 64'(err_n), 64'h2);
      check("sticky", spi_error, 64'h1);
      $display("test overlong frame done");
      frame(16, 64'h5500, 64'hC03C, 0);
      // Each fault event latches its own flag
      for (int i = 0; i < 6; i++)
      begin
         @(negedge core_clk);
         fin = 6'h01 << i;
         @(negedge core_clk);
         fin = 6'h00;
         @(negedge core_clk);
         check("faults", fault_flags, (64'h2 << i) - 64'h1);
      end
      $display("test fault latching done");
      frame(16, 64'h5500, 64'hFF3C, 0);
      // Chain of two, this device first, with global clear
      frame(48, 64'h82A0152A7799, 64'hFF82A03C2A77, 1);
      check("clears", 64'(clr_n), 64'h1);
      check("chain", {fault_flags, spi_error, device_count, chain_position}, 64'h80);
      check("write", {wr_addr, wr_data}, 64'h1577);
      frame(16, 64'h5500, 64'hC077, 0);
      print_verdict();
   end
endmodule
bind sdc_spi_target sdc_spi_chk chk (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk),
   .chip_select_n(chip_select_n), .sdo(sdo), .sdo_oe(sdo_oe),
   .supply_undervoltage_flag(supply_undervoltage_flag),
   .pump_undervoltage_flag(pump_undervoltage_flag), .overcurrent_flag(overcurrent_flag),
   .stall_flag(stall_flag), .thermal_flag(thermal_flag), .open_load_flag(open_load_flag),
   .wr_stb(wr_stb), .fault_flags(fault_flags), .spi_error(spi_error),
   .frame_err(frame_err), .global_clear(global_clear));
`default_nettype wire
